/* include/label_if.sv */
// Purpose: Request link carrying the labelling bundle beside each request.
// Assumes: Valid/ready handshake; label qualified by valid.
// Notes:   No clocking block; both ends share clk.
`timescale 1ns/10ps
interface label_if (
   input wire logic clk
);
   logic                              req_valid;
   logic                              req_ready;
   logic [label_pkg::ADDR_W-1:0]      req_addr;
   logic                              req_write;
   logic [label_pkg::DATA_W-1:0]      req_wdata;
   label_pkg::label_s                 req_label;

   modport requester (
      output req_valid,
      input  req_ready,
      output req_addr,
      output req_write,
      output req_wdata,
      output req_label
   );
   modport completer (
      input  req_valid,
      output req_ready,
      input  req_addr,
      input  req_write,
      input  req_wdata,
      input  req_label
   );
endinterface : label_if

/* include/label_pkg.sv */
// Purpose: Shared widths, defaults and encodings for the request labelling bundle.
// Assumes: One system clock; labels travel beside the request they describe.
// Notes:   Widths sit at their architectural ceilings.
package label_pkg;
   // ****************************************
   // Field widths
   // ****************************************
   localparam int PARTITION_ID_W = 16;
   localparam int MONGRP_W = 8;
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int LINES    = 4;
   localparam int IDX_W    = 2;

   // ****************************************
   // Defaults and encodings
   // ****************************************
   localparam logic [PARTITION_ID_W-1:0] DEFAULT_PARTITION_ID = 16'h0000;
   localparam logic [MONGRP_W-1:0] DEFAULT_MONGRP = 8'h00;
   localparam logic                SPACE_SECURE   = 1'b0;
   localparam logic                SPACE_NONSEC   = 1'b1;
   localparam logic [PARTITION_ID_W-1:0] MAX_PARTITION_ID_NS  = 16'h003f;
   localparam logic [PARTITION_ID_W-1:0] MAX_PARTITION_ID_S   = 16'h000f;
   localparam logic [MONGRP_W-1:0] MAX_MONGRP     = 8'h03;
   // Completer address window serviced locally (top nibble)
   localparam logic [3:0]          LOCAL_REGION   = 4'hf;
   // Address field positions of the line index and the local window
   localparam int                  IDX_LSB        = 2;
   localparam int                  REGION_LSB     = 28;

   typedef struct packed {
      logic [PARTITION_ID_W-1:0] partition_id;
      logic [MONGRP_W-1:0] monitor_group;
      logic                nonsecure_space_flag;
   } label_s;

   localparam label_s LABEL_RESET = '{DEFAULT_PARTITION_ID, DEFAULT_MONGRP, SPACE_SECURE};

   function automatic logic partition_id_in_range(input logic [PARTITION_ID_W-1:0] id, input logic ns);
      partition_id_in_range = ns ? (id <= MAX_PARTITION_ID_NS) : (id <= MAX_PARTITION_ID_S);
   endfunction : partition_id_in_range
endpackage : label_pkg

/* test/label_asserts.sv */
// Purpose: Link assertions for labelled requests.
// Assumes: One clock; async active-low reset.
// Notes:   Sees only the link signals.
`timescale 1ns/10ps
module label_asserts (
   input wire logic                         clk,
   input wire logic                         rst_n_in,
   input wire logic                         req_valid,
   input wire logic                         req_ready,
   input wire logic [label_pkg::ADDR_W-1:0] req_addr,
   input wire logic                         req_write,
   input wire logic [label_pkg::DATA_W-1:0] req_wdata,
   input wire label_pkg::label_s            req_label
);
   // ****
   // Handshake and label checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n_in);
   sequence s_wait;
      req_valid && !req_ready;
   endsequence
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_sec;
      req_valid && !req_label.nonsecure_space_flag;
   endsequence
   sequence s_nsec;
      req_valid && req_label.nonsecure_space_flag;
   endsequence
   label_hold_a: assert property (s_wait |=> req_valid && $stable(req_label))
      else $error("label changed while waiting");
   request_hold_a: assert property (s_wait |=> $stable({req_addr, req_write, req_wdata}))
      else $error("request changed while waiting");
   drop_after_take_a: assert property (s_take |=> !req_valid)
      else $error("valid held after take");
   drop_when_taken_a: assert property ($fell(req_valid) |-> $past(req_ready))
      else $error("valid dropped untaken");
   secure_range_a: assert property (s_sec |-> req_label.partition_id <= label_pkg::MAX_PARTITION_ID_S)
      else $error("secure id out of range");
   nonsec_range_a: assert property (s_nsec |-> req_label.partition_id <= label_pkg::MAX_PARTITION_ID_NS)
      else $error("nonsecure id out of range");
   group_range_a: assert property (req_valid |-> req_label.monitor_group <= label_pkg::MAX_MONGRP)
      else $error("group out of range");
   idle_start_a: assert property ($rose(rst_n_in) |-> !req_valid)
      else $error("request at reset release");
endmodule : label_asserts

/* test/partition_label_propagation_bench.sv */
// Purpose: Self-checking bench for requester and completer joined by the link.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Reset values first, then table rows, then a downstream stall.
`timescale 1ns/10ps
module partition_label_propagation_bench;
   // ****
   // Cases
   // ****
   typedef struct packed {
      logic [4:0]        ctl;
      logic [1:0]        res;
      logic [15:0]       id;
      logic [7:0]        grp;
      logic [31:0]       addr;
      label_pkg::label_s exp;
   } row_s;
   // Ctl: enable, nonsecure, terminating, labelled downstream, write; res: local, hit
   row_s rows [12] = '{
      '{5'h0b, 2'h0, 16'h5, 8'h2, 32'h100, '{16'h0, 8'h0, 1'h1}},
      '{5'h03, 2'h0, 16'h5, 8'h2, 32'h104, '{16'h0, 8'h0, 1'h0}},
      '{5'h1b, 2'h0, 16'h3f, 8'h3, 32'h108, '{16'h3f, 8'h3, 1'h1}},
      '{5'h13, 2'h0, 16'hf, 8'h1, 32'h10c, '{16'hf, 8'h1, 1'h0}},
      '{5'h13, 2'h0, 16'h10, 8'h1, 32'h110, '{16'h0, 8'h0, 1'h0}},
      '{5'h1b, 2'h0, 16'h5, 8'h4, 32'h114, '{16'h5, 8'h0, 1'h1}},
      '{5'h1b, 2'h2, 16'h7, 8'h2, 32'hf0000000, '{16'h7, 8'h2, 1'h1}},
      '{5'h1f, 2'h2, 16'h9, 8'h1, 32'h200, '{16'h9, 8'h1, 1'h1}},
      '{5'h19, 2'h0, 16'h9, 8'h1, 32'h300, label_pkg::LABEL_RESET},
      '{5'h1a, 2'h0, 16'h2, 8'h3, 32'h40, '{16'h2, 8'h3, 1'h1}},
      '{5'h1a, 2'h3, 16'h2, 8'h3, 32'h40, '{16'h2, 8'h3, 1'h1}},
      '{5'h1a, 2'h3, 16'h3, 8'h1, 32'h40, '{16'h2, 8'h3, 1'h1}}
   };
   logic              clk, rst_n, uval, dr, uready, gerr, dv, ldone, hit, dwr;
   logic [15:0]       maxid, fid, sfid;
   logic [31:0]       daddr, dwd;
   label_pkg::label_s dlab, llab;
   row_s              cur;
   int                n_fail, tests_run;
   label_if lnk (.clk(clk));
   label_requester u_label_requester (.clk_in(clk), .rst_n_in(rst_n), .label_gen_enable_in(cur.ctl[4]),
      .nonsecure_state_in(cur.ctl[3]), .cfg_partition_id_in(cur.id), .cfg_monitor_group_in(cur.grp),
      .user_valid_in(uval), .user_addr_in(cur.addr), .user_write_in(cur.ctl[0]), .user_wdata_in(~cur.addr),
      .user_ready_out(uready), .gen_error_out(gerr), .max_partition_id_out(maxid), .link(lnk));
   label_completer u_label_completer (.clk_in(clk), .rst_n_in(rst_n), .terminating_in(cur.ctl[2]),
      .downstream_labelled_in(cur.ctl[1]), .down_ready_in(dr), .down_valid_out(dv), .down_addr_out(daddr),
      .down_write_out(dwr), .down_wdata_out(dwd), .down_label_out(dlab), .local_done_out(ldone),
      .local_label_out(llab), .hit_out(hit), .component_feature_id_out(fid),
      .component_secure_feature_id_out(sfid), .link(lnk));
   label_asserts u_label_asserts (.clk(clk), .rst_n_in(rst_n), .req_valid(lnk.req_valid),
      .req_ready(lnk.req_ready), .req_addr(lnk.req_addr), .req_write(lnk.req_write),
      .req_wdata(lnk.req_wdata), .req_label(lnk.req_label));
   function automatic logic exp_err(input row_s r);
      return r.ctl[4] && ((r.ctl[3] ? r.id > label_pkg::MAX_PARTITION_ID_NS : r.id > label_pkg::MAX_PARTITION_ID_S)
         || r.grp > label_pkg::MAX_MONGRP);
   endfunction : exp_err
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_lab(input label_pkg::label_s got, input label_pkg::label_s exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_lab
   // One request issued per call; returns once a result shows or after 20 cycles
   task automatic send(input row_s r);
      cur = r;
      uval = 1'h1;
      @(negedge clk);
      uval = 1'h0;
      for (int k = 0; k < 20 && dv !== 1'h1 && ldone !== 1'h1; k++) @(negedge clk);
   endtask : send
   task automatic end_sim();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // Budget is many times the expected run
   initial begin
      repeat (3000) @(negedge clk);
      n_fail++;
      end_sim();
   end
   initial begin
      cur = '0;
      uval = 1'h0;
      dr = 1'h1;
      rst_n = 1'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      chk_val({fid, sfid}, {label_pkg::MAX_PARTITION_ID_NS, label_pkg::MAX_PARTITION_ID_S});
      chk_lab(dlab, label_pkg::LABEL_RESET);
      $display("reset test done");
      foreach (rows[i]) begin
         send(rows[i]);
         chk_val(32'({ldone, dv, hit}), 32'({rows[i].res[1], !rows[i].res[1], rows[i].res[0]}));
         chk_lab((ldone === 1'h1) ? llab : dlab, rows[i].exp);
         chk_val(32'(gerr), 32'(exp_err(rows[i])));
         chk_val(32'(uready), 32'h1);
         if (dv === 1'h1) chk_val(daddr, rows[i].addr);
         if (dv === 1'h1) chk_val(dwd, ~rows[i].addr);
         if (dv === 1'h1) chk_val(32'(dwr), 32'(rows[i].ctl[0]));
         $display("row %0d done", i);
         repeat (2) @(negedge clk);
      end
      chk_val(32'(maxid), 32'(label_pkg::MAX_PARTITION_ID_NS));
      // Stall downstream so the second request waits on the link
      dr = 1'h0;
      send(rows[2]);
      send(rows[3]);
      repeat (4) @(negedge clk);
      chk_lab(dlab, rows[2].exp);
      chk_val(32'({dv, lnk.req_valid, lnk.req_ready, uready}), 32'hc);
      dr = 1'h1;
      for (int k = 0; k < 20 && dlab !== rows[3].exp; k++) @(negedge clk);
      chk_lab(dlab, rows[3].exp);
      $display("stall test done");
      end_sim();
   end
endmodule : partition_label_propagation_bench

/* verilog/label_completer.sv */
// Purpose: Memory-system component end: buffers, caches and forwards labelled requests.
// Assumes: Downstream user side may stall; one request buffered at a time.
// Notes:   Direct-mapped label store for allocated lines.
//          Read hits report the label recorded when the line was allocated.
//          Only one request buffered: throughput traded for area.
`timescale 1ns/10ps
module label_completer (
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire logic                                terminating_in,
   input  wire logic                                downstream_labelled_in,
   input  wire logic                                down_ready_in,
   output logic                                     down_valid_out,
   output logic [label_pkg::ADDR_W-1:0]             down_addr_out,
   output logic                                     down_write_out,
   output logic [label_pkg::DATA_W-1:0]             down_wdata_out,
   output label_pkg::label_s                        down_label_out,
   output logic                                     local_done_out,
   output label_pkg::label_s                        local_label_out,
   output logic                                     hit_out,
   output logic [label_pkg::PARTITION_ID_W-1:0]           component_feature_id_out,
   output logic [label_pkg::PARTITION_ID_W-1:0]           component_secure_feature_id_out,
   label_if.completer                               link
);
   // ****************************************
   // Identification
   // ****************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         component_feature_id_out        <= label_pkg::MAX_PARTITION_ID_NS;
         component_secure_feature_id_out <= label_pkg::MAX_PARTITION_ID_S;
      end else begin
         component_feature_id_out        <= label_pkg::MAX_PARTITION_ID_NS;
         component_secure_feature_id_out <= label_pkg::MAX_PARTITION_ID_S;
      end
   end

   // ****************************************
   // Cache label store
   // ****************************************
   logic                              line_valid_r [label_pkg::LINES];
   logic [label_pkg::ADDR_W-1:0]      line_tag_r   [label_pkg::LINES];
   label_pkg::label_s                 line_label_r [label_pkg::LINES];
   logic [label_pkg::IDX_W-1:0]       idx;
   logic                              hit;
   logic                              is_local;
   logic                              take;
   logic                              ready_r;

   always_comb begin
      idx      = link.req_addr[label_pkg::IDX_LSB +: label_pkg::IDX_W];
      hit      = line_valid_r[idx] && line_tag_r[idx] == link.req_addr && !link.req_write;
      is_local = terminating_in || hit
                 || link.req_addr[label_pkg::REGION_LSB +: 4] == label_pkg::LOCAL_REGION;
   end

   // Stall input while the single buffer is occupied downstream;
   // ready is a flop of its own so the link sees no gate after a register
   assign link.req_ready = ready_r;
   assign take           = link.req_valid && ready_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < label_pkg::LINES; i++) begin
            line_valid_r[i] <= 1'b0;
            line_tag_r[i]   <= '0;
            line_label_r[i] <= label_pkg::LABEL_RESET;
         end
      end else if (take && !terminating_in && !hit && !link.req_write) begin
         line_valid_r[idx] <= 1'b1;
         line_tag_r[idx]   <= link.req_addr;
         line_label_r[idx] <= link.req_label;
      end
   end

   // ****************************************
   // Local service
   // ****************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         local_done_out  <= 1'b0;
         hit_out         <= 1'b0;
         local_label_out <= label_pkg::LABEL_RESET;
      end else begin
         local_done_out  <= take && is_local;
         hit_out         <= take && hit;
         // A hit is charged to the partition that allocated the line
         if (take && hit) begin
            local_label_out <= line_label_r[idx];
         end else if (take && is_local) begin
            local_label_out <= link.req_label;
         end else begin
            local_label_out <= label_pkg::LABEL_RESET;
         end
      end
   end

   // ****************************************
   // Downstream buffer
   // ****************************************
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         down_valid_out <= 1'b0;
         down_addr_out  <= '0;
         down_write_out <= 1'b0;
         down_wdata_out <= '0;
         down_label_out <= label_pkg::LABEL_RESET;
         ready_r        <= 1'b1;
      end else if (take && !is_local) begin
         down_valid_out <= 1'b1;
         ready_r        <= 1'b0;
         down_addr_out  <= link.req_addr;
         down_write_out <= link.req_write;
         down_wdata_out <= link.req_wdata;
         // Bundle held unmodified while buffered, or the reset label when downstream is not labelled
         down_label_out <= downstream_labelled_in ? link.req_label
                                                  : label_pkg::LABEL_RESET;
      end else if (down_valid_out && down_ready_in) begin
         down_valid_out <= 1'b0;
         ready_r        <= 1'b1;
      end
   end
endmodule : label_completer

/* verilog/label_requester.sv */
// Purpose: Requester end: generates the labelling bundle and issues requests.
// Assumes: User-side inputs are on clk_in; configuration is static around a request.
// Notes:   Error fallback picks the default monitor group.
`timescale 1ns/10ps
module label_requester (
   input  wire logic                                clk_in,
   input  wire logic                                rst_n_in,
   input  wire logic                                label_gen_enable_in,
   input  wire logic                                nonsecure_state_in,
   input  wire logic [label_pkg::PARTITION_ID_W-1:0]      cfg_partition_id_in,
   input  wire logic [label_pkg::MONGRP_W-1:0]      cfg_monitor_group_in,
   input  wire logic                                user_valid_in,
   input  wire logic [label_pkg::ADDR_W-1:0]        user_addr_in,
   input  wire logic                                user_write_in,
   input  wire logic [label_pkg::DATA_W-1:0]        user_wdata_in,
   output logic                                     user_ready_out,
   output logic                                     gen_error_out,
   output logic [label_pkg::PARTITION_ID_W-1:0]           max_partition_id_out,
   label_if.requester                               link
);
   // ****************************************
   // Label generation
   // ****************************************
   label_pkg::label_s gen_label;
   logic              pid_err;
   logic              grp_err;

   always_comb begin
      pid_err = !label_pkg::partition_id_in_range(cfg_partition_id_in, nonsecure_state_in);
      grp_err = cfg_monitor_group_in > label_pkg::MAX_MONGRP;
      gen_label.nonsecure_space_flag = nonsecure_state_in;
      if (!label_gen_enable_in) begin
         gen_label.partition_id  = label_pkg::DEFAULT_PARTITION_ID;
         gen_label.monitor_group = label_pkg::DEFAULT_MONGRP;
      end else if (pid_err || grp_err) begin
         gen_label.partition_id  = pid_err ? label_pkg::DEFAULT_PARTITION_ID
                                           : cfg_partition_id_in;
         gen_label.monitor_group = label_pkg::DEFAULT_MONGRP;
      end else begin
         // Programmed id is already physical: no virtual id spaces here
         gen_label.partition_id  = cfg_partition_id_in;
         gen_label.monitor_group = cfg_monitor_group_in;
      end
   end

   // ****************************************
   // Request issue register
   // ****************************************
   logic busy_r;

   // Ready has a flop of its own so the user port sees no gate after a register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_r          <= 1'b0;
         user_ready_out  <= 1'b1;
         link.req_valid  <= 1'b0;
         link.req_addr   <= '0;
         link.req_write  <= 1'b0;
         link.req_wdata  <= '0;
         link.req_label  <= label_pkg::LABEL_RESET;
      end else if (!busy_r && user_valid_in) begin
         busy_r          <= 1'b1;
         user_ready_out  <= 1'b0;
         link.req_valid  <= 1'b1;
         link.req_addr   <= user_addr_in;
         link.req_write  <= user_write_in;
         link.req_wdata  <= user_wdata_in;
         link.req_label  <= gen_label;
      end else if (busy_r && link.req_ready) begin
         busy_r          <= 1'b0;
         user_ready_out  <= 1'b1;
         link.req_valid  <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gen_error_out        <= 1'b0;
         max_partition_id_out <= label_pkg::DEFAULT_PARTITION_ID;
      end else begin
         gen_error_out        <= label_gen_enable_in && (pid_err || grp_err);
         max_partition_id_out <= label_pkg::MAX_PARTITION_ID_NS;
      end
   end
endmodule : label_requester
